/* common/cso_pkg.sv */
// package for the clock start-up and reference output block
// assumes one bus clock; oscillator levels are sampled into it
package cso_pkg;
	localparam int ADDR_W = 8;
	localparam int DIV_W = 15;
	localparam int NUM_REF = 2;
	localparam int OST_CYCLES_DEF = 1024;
	// register byte offsets
	localparam logic [7:0] OFF_OSC = 8'h00;
	localparam logic [7:0] OFF_CFG = 8'h04;
	localparam logic [7:0] OFF_PMD = 8'h08;
	localparam logic [7:0] OFF_STAT = 8'h0c;
	localparam logic [7:0] OFF_REF_BASE = 8'h10;
	localparam logic [7:0] OFF_REF_STRIDE = 8'h10;
	localparam logic [7:0] OFF_REF_CON = 8'h00;
	localparam logic [7:0] OFF_REF_SEL = 8'h04;
	localparam logic [7:0] OFF_REF_DIV = 8'h08;
	// field positions
	localparam int NOSC_LSB = 0;
	localparam int CURRENT_OSC_SELECT_LSB = 4;
	localparam int PEND_BIT = 8;
	localparam int CFG_TS_BIT = 7;
	localparam int CFG_FOSC_LSB = 0;
	localparam int CON_ON_BIT = 7;
	localparam int CON_RUN_IN_SLEEP_BIT = 3;
	localparam int CON_ACT_BIT = 0;
	// reset values and AXI response codes
	localparam logic [7:0] CFG_RESET = 8'h82;
	localparam logic [7:0] CON_RESET = 8'h00;
	localparam logic [1:0] PMD_RESET = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// oscillator selection codes
	localparam logic [2:0] OSC_FRC = 3'h0;
	localparam logic [2:0] OSC_PRI = 3'h2;
	localparam logic [2:0] OSC_SEC = 3'h4;
	localparam logic [2:0] OSC_LF = 3'h5;
	// reference source codes, also index into the source level vector
	localparam logic [3:0] REF_SYS = 4'h0;
	localparam logic [3:0] REF_PERIPH = 4'h1;
	localparam logic [3:0] REF_PRI = 4'h2;
	localparam logic [3:0] REF_SEC = 4'h3;
	localparam logic [3:0] REF_LF = 4'h4;
	localparam logic [3:0] REF_FRC = 4'h5;
	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_IDLE = 2'b01,
		PWR_SLEEP = 2'b10
	} cso_pwr_type;
endpackage : cso_pkg

/* rtl/cso_sync2.sv */
// two-stage synchroniser for levels entering the bus clock domain
// assumes inputs are asynchronous levels
`timescale 1ns/1ps
module cso_sync2 #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : cso_sync2

/* rtl/cso_ref_out.sv */
// one reference clock output: source select, divider, glitch-free gate
// assumes source levels are already synchronised to aclk
`timescale 1ns/1ps
module cso_ref_out
	import cso_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [5:0] src_lvl,
	input wire logic [3:0] sel,
	input wire logic [DIV_W-1:0] div,
	input wire logic on,
	input wire logic run_in_sleep,
	input wire logic module_disable,
	input wire logic sleep,
	output logic out_pin,
	output logic out_oe,
	output logic active,
	output logic osc_keep
);
	logic src;
	logic src_d;
	logic tick;
	logic div_q;
	logic en;
	logic run;
	logic low_ok;
	logic osc_src;
	logic [DIV_W-1:0] cnt;

	always_comb begin
		src = 1'b0;
		if (sel <= REF_FRC) begin
			src = src_lvl[sel[2:0]];
		end
	end
	assign osc_src = (sel >= REF_PRI) && (sel <= REF_FRC);
	// sleep stops all but oscillator sources held by run_in_sleep
	assign run = on && !module_disable && (sel <= REF_FRC) &&
		(!sleep || (run_in_sleep && osc_src));
	assign tick = src && !src_d;
	assign low_ok = (div == '0) ? !src : !div_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_d <= 1'b0;
		end else begin
			src_d <= src;
		end
	end

	// enable taken on a source rising edge, dropped only when output low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en <= 1'b0;
		end else if (!en && run && tick) begin
			en <= 1'b1;
		end else if (en && !run && low_ok) begin
			en <= 1'b0;
		end
	end

	// toggles every div source periods, ratio 2*div; div 0 passes through
	always_ff @(posedge aclk) begin
		if (!aresetn || !en) begin
			cnt <= '0;
			div_q <= 1'b0;
		end else if (tick && div != '0) begin
			if (cnt + DIV_W'(1) >= div) begin
				cnt <= '0;
				div_q <= !div_q;
			end else begin
				cnt <= cnt + DIV_W'(1);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_pin <= 1'b0;
			out_oe <= 1'b0;
			osc_keep <= 1'b0;
		end else begin
			out_pin <= en && ((div == '0) ? src : div_q);
			out_oe <= en;
			osc_keep <= en && sleep && osc_src;
		end
	end
	assign active = en;
endmodule : cso_ref_out

/* rtl/cso_top.sv */
// oscillator switch control, two-speed start-up, two reference outputs
// assumes an AXI4-Lite master on aclk and core power requests on aclk
`timescale 1ns/1ps
module cso_top
	import cso_pkg::*;
#(
	parameter int OST_CYCLES = OST_CYCLES_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleep_req,
	input wire logic idle_req,
	input wire logic wake_req,
	input wire logic primary_oscillator_in,
	input wire logic secondary_oscillator_in,
	input wire logic low_freq_internal_osc_in,
	input wire logic fast_internal_rc_in,
	input wire logic [3:0] osc_stable_in,
	input wire logic peripheral_clock_source,
	output logic [2:0] sys_clk_select,
	output logic osc_startup_timer_clear,
	output logic pll_stop,
	output logic sleep_active,
	output logic idle_active,
	output logic ref_clock_out_pin_a,
	output logic ref_clock_out_pin_a_oe,
	output logic ref_clock_out_pin_b,
	output logic ref_clock_out_pin_b_oe,
	output logic [1:0] osc_keep_req
);
	localparam int OST_W = $clog2(OST_CYCLES + 1);

	logic [7:0] pin_s;
	logic [3:0] osc_lvl;
	logic [3:0] stable_s;
	logic sys_tgl;
	logic [5:0] src_lvl;
	logic [2:0] new_osc_select_field;
	logic [2:0] current_osc_select_field;
	logic [7:0] config_word_2_low;
	logic [1:0] module_disable_reg3;
	logic [7:0] ref_out_control [NUM_REF];
	logic [3:0] ref_source_select [NUM_REF];
	logic [DIV_W-1:0] ref_div [NUM_REF];
	logic [NUM_REF-1:0] ref_pin;
	logic [NUM_REF-1:0] ref_oe;
	logic [NUM_REF-1:0] ref_active;
	cso_pwr_type pwr;
	logic boot;
	logic pending;
	logic target_ready;
	logic ost_done;
	logic [OST_W-1:0] ost_cnt;
	logic wr_go;
	logic rd_go;
	logic osc_wr;
	logic abandon;
	logic sleep_cancel;
	logic ts_en;
	logic [2:0] fosc;
	logic [31:0] wmask;
	logic [31:0] rd_word;
	logic rd_hit;
	logic wr_hit;

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		logic h;
		h = 1'b0;
		if (a == OFF_OSC || a == OFF_CFG || a == OFF_PMD) begin
			h = 1'b1;
		end else if (a == OFF_STAT) begin
			h = 1'b1;
		end else if (a >= OFF_REF_BASE &&
				a < OFF_REF_BASE + OFF_REF_STRIDE * NUM_REF) begin
			h = (a[3:0] == OFF_REF_CON[3:0]) ||
				(a[3:0] == OFF_REF_SEL[3:0]) ||
				(a[3:0] == OFF_REF_DIV[3:0]);
		end
		return h;
	endfunction : addr_hit

	function automatic logic osc_ready(input logic [2:0] code,
			input logic [3:0] st);
		logic r;
		r = 1'b1;
		case (code)
			OSC_FRC: r = st[3];
			OSC_PRI: r = st[0];
			OSC_SEC: r = st[1];
			OSC_LF: r = st[2];
			default: r = 1'b1;
		endcase
		return r;
	endfunction : osc_ready

	// oscillator pins and their ready flags cross into aclk
	cso_sync2 #(
		.W(8)
	) u_pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({osc_stable_in, fast_internal_rc_in, low_freq_internal_osc_in,
			secondary_oscillator_in, primary_oscillator_in}),
		.q(pin_s)
	);
	assign osc_lvl = pin_s[3:0];
	assign stable_s = pin_s[7:4];

	// raw system clock seen as a level at half the bus rate
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_tgl <= 1'b0;
		end else begin
			sys_tgl <= !sys_tgl;
		end
	end
	assign src_lvl = {osc_lvl[3], osc_lvl[2], osc_lvl[1], osc_lvl[0],
		peripheral_clock_source, sys_tgl};

	// AXI4-Lite write: address and data taken together
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign wr_hit = addr_hit(s_axi_awaddr);
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[8*b +: 8] = {8{s_axi_wstrb[b]}};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			config_word_2_low <= CFG_RESET;
		end else if (wr_go && s_axi_awaddr == OFF_CFG && s_axi_wstrb[0]) begin
			config_word_2_low <= s_axi_wdata[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			module_disable_reg3 <= PMD_RESET;
		end else if (wr_go && s_axi_awaddr == OFF_PMD && s_axi_wstrb[0]) begin
			module_disable_reg3 <= s_axi_wdata[1:0];
		end
	end

	// per-instance control, source and divider registers
	for (genvar i = 0; i < NUM_REF; i++) begin : g_ref
		localparam logic [7:0] BASE = OFF_REF_BASE + 8'(i) * OFF_REF_STRIDE;
		logic [31:0] div_new;
		assign div_new = (32'(ref_div[i]) & ~wmask) | (s_axi_wdata & wmask);
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ref_out_control[i] <= CON_RESET;
			end else if (wr_go && s_axi_awaddr == BASE + OFF_REF_CON &&
					s_axi_wstrb[0]) begin
				ref_out_control[i] <= s_axi_wdata[7:0] &
					~(8'h01 << CON_ACT_BIT);
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ref_source_select[i] <= REF_SYS;
			end else if (wr_go && s_axi_awaddr == BASE + OFF_REF_SEL &&
					s_axi_wstrb[0]) begin
				ref_source_select[i] <= s_axi_wdata[3:0];
			end
		end
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ref_div[i] <= '0;
			end else if (wr_go && s_axi_awaddr == BASE + OFF_REF_DIV) begin
				ref_div[i] <= div_new[DIV_W-1:0];
			end
		end
		cso_ref_out u_ref (
			.aclk(aclk),
			.aresetn(aresetn),
			.src_lvl(src_lvl),
			.sel(ref_source_select[i]),
			.div(ref_div[i]),
			.on(ref_out_control[i][CON_ON_BIT]),
			.run_in_sleep(ref_out_control[i][CON_RUN_IN_SLEEP_BIT]),
			.module_disable(module_disable_reg3[i]),
			.sleep(sleep_active),
			.out_pin(ref_pin[i]),
			.out_oe(ref_oe[i]),
			.active(ref_active[i]),
			.osc_keep(osc_keep_req[i])
		);
	end
	assign ref_clock_out_pin_a = ref_pin[0];
	assign ref_clock_out_pin_a_oe = ref_oe[0];
	assign ref_clock_out_pin_b = ref_pin[1];
	assign ref_clock_out_pin_b_oe = ref_oe[1];

	// power state from core requests
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr <= PWR_RUN;
		end else begin
			case (pwr)
				PWR_RUN: begin
					if (sleep_req) begin
						pwr <= PWR_SLEEP;
					end else if (idle_req) begin
						pwr <= PWR_IDLE;
					end
				end
				PWR_IDLE: begin
					if (wake_req) begin
						pwr <= PWR_RUN;
					end
				end
				PWR_SLEEP: begin
					if (wake_req) begin
						pwr <= PWR_RUN;
					end
				end
				default: pwr <= PWR_RUN;
			endcase
		end
	end
	assign sleep_active = (pwr == PWR_SLEEP);
	assign idle_active = (pwr == PWR_IDLE);

	// fail-safe monitor bits of the config byte are deliberately unused
	assign ts_en = config_word_2_low[CFG_TS_BIT];
	assign fosc = config_word_2_low[CFG_FOSC_LSB +: 3];
	assign osc_wr = wr_go && s_axi_awaddr == OFF_OSC && s_axi_wstrb[0];
	assign pending = new_osc_select_field != current_osc_select_field;
	assign abandon = osc_wr && pending &&
		s_axi_wdata[NOSC_LSB +: 3] == current_osc_select_field;
	assign sleep_cancel = pwr == PWR_RUN && sleep_req && pending;
	assign target_ready = osc_ready(new_osc_select_field, stable_s);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot <= 1'b1;
		end else begin
			boot <= 1'b0;
		end
	end

	// selection fields; cancel by Sleep wins over a software write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			new_osc_select_field <= OSC_FRC;
			current_osc_select_field <= OSC_FRC;
		end else if (boot) begin
			new_osc_select_field <= fosc;
			current_osc_select_field <= ts_en ? OSC_FRC : fosc;
		end else if (sleep_cancel) begin
			new_osc_select_field <= current_osc_select_field;
		end else if (pwr == PWR_SLEEP && wake_req) begin
			if (ts_en) begin
				new_osc_select_field <= fosc;
				current_osc_select_field <= OSC_FRC;
			end
		end else if (osc_wr) begin
			new_osc_select_field <= s_axi_wdata[NOSC_LSB +: 3];
		end else if (pwr == PWR_RUN && pending && target_ready &&
				ost_done) begin
			current_osc_select_field <= new_osc_select_field;
		end
	end
	// idle exit leaves the fields alone, clock stays as selected

	// start-up timer counts once the target reports stable
	always_ff @(posedge aclk) begin
		if (!aresetn || !pending || abandon || sleep_cancel) begin
			ost_cnt <= '0;
		end else if (target_ready && !ost_done) begin
			ost_cnt <= ost_cnt + OST_W'(1);
		end
	end
	assign ost_done = ost_cnt == OST_W'(OST_CYCLES);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_startup_timer_clear <= 1'b0;
			pll_stop <= 1'b0;
			sys_clk_select <= OSC_FRC;
		end else begin
			osc_startup_timer_clear <= abandon || sleep_cancel;
			pll_stop <= abandon || sleep_cancel;
			sys_clk_select <= current_osc_select_field;
		end
	end

	// AXI4-Lite read
	assign rd_go = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_hit = addr_hit(s_axi_araddr);
	always_comb begin
		logic [ADDR_W-1:0] rel;
		int idx;
		rd_word = '0;
		rel = s_axi_araddr - OFF_REF_BASE;
		idx = int'(rel[7:4]);
		if (s_axi_araddr == OFF_OSC) begin
			rd_word[NOSC_LSB +: 3] = new_osc_select_field;
			rd_word[CURRENT_OSC_SELECT_LSB +: 3] = current_osc_select_field;
			rd_word[PEND_BIT] = pending;
		end else if (s_axi_araddr == OFF_CFG) begin
			rd_word[7:0] = config_word_2_low;
		end else if (s_axi_araddr == OFF_PMD) begin
			rd_word[1:0] = module_disable_reg3;
		end else if (s_axi_araddr == OFF_STAT) begin
			rd_word[0] = pending;
			rd_word[1] = ost_done;
			rd_word[5:2] = stable_s;
			rd_word[7:6] = pwr;
		end else if (rd_hit && idx < NUM_REF) begin
			if (rel[3:0] == OFF_REF_CON[3:0]) begin
				rd_word[7:0] = ref_out_control[idx];
				rd_word[CON_ACT_BIT] = ref_active[idx];
			end else if (rel[3:0] == OFF_REF_SEL[3:0]) begin
				rd_word[3:0] = ref_source_select[idx];
			end else begin
				rd_word[DIV_W-1:0] = ref_div[idx];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : cso_top

/* dv/cso_checker.sv */
// port assertions for the clock start-up and reference output block
// assumes binding into cso_top, one clock domain on aclk
`timescale 1ns/1ps
module cso_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [2:0] sys_clk_select,
	input wire logic osc_startup_timer_clear,
	input wire logic pll_stop,
	input wire logic sleep_active,
	input wire logic idle_active,
	input wire logic ref_clock_out_pin_a,
	input wire logic ref_clock_out_pin_a_oe,
	input wire logic ref_clock_out_pin_b,
	input wire logic ref_clock_out_pin_b_oe
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wr_answer_a: assert property (s_axi_awvalid && s_axi_wvalid &&
		!s_axi_bvalid |=> s_axi_bvalid) else $error("write not answered");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read not held");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write not held");
	clr_pll_a: assert property (osc_startup_timer_clear |-> pll_stop)
		else $error("timer clear without pll stop");
	clr_pulse_a: assert property (osc_startup_timer_clear |=>
		!osc_startup_timer_clear) else $error("timer clear too long");
	sleep_hold_a: assert property (sleep_active ##1 sleep_active |->
		$stable(sys_clk_select)) else $error("clock changed in sleep");
	idle_exit_a: assert property ($fell(idle_active) |->
		$stable(sys_clk_select)) else $error("clock changed on idle exit");
	off_low_a: assert property (!ref_clock_out_pin_a_oe |->
		!ref_clock_out_pin_a) else $error("pin a driven while off");
	b_off_low_a: assert property (!ref_clock_out_pin_b_oe |->
		!ref_clock_out_pin_b) else $error("pin b driven while off");
	pulse_min_a: assert property ($rose(ref_clock_out_pin_a) |=>
		ref_clock_out_pin_a) else $error("glitch on pin a");
	b_pulse_min_a: assert property ($rose(ref_clock_out_pin_b) |=>
		ref_clock_out_pin_b) else $error("glitch on pin b");
	c_clear: cover property (osc_startup_timer_clear);
	c_idle: cover property ($fell(idle_active));
	c_ref_a: cover property ($rose(ref_clock_out_pin_a_oe));
	c_ref_b: cover property ($rose(ref_clock_out_pin_b_oe));
endmodule : cso_checker

bind cso_top cso_checker u_chk (.*);

/* dv/cso_ref_sink.sv */
// receiver model of a reference clock pin: counts rises, measures period
// assumes pin and oe are registered on aclk
`timescale 1ns/1ps
module cso_ref_sink (
	input wire logic aclk,
	input wire logic pin,
	input wire logic oe,
	output int period,
	output int rises
);
	int cnt;
	logic last = 1'b0;
	always @(posedge aclk) begin
		last <= pin;
		cnt <= cnt + 1;
		if (oe && pin && !last) begin
			period <= cnt + 1;
			cnt <= 0;
			rises <= rises + 1;
		end
	end
endmodule : cso_ref_sink

/* dv/tb.sv */
// self-checking bench for the clock start-up and reference output block
// assumes cso_top with a short start-up timer and the bound checker
`timescale 1ns/1ps
module tb;
	import cso_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0] s_axi_wstrb = 4'hf, osc_stable_in = 4'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, osc_keep_req;
	logic sleep_req = 1'b0, idle_req = 1'b0, wake_req = 1'b0;
	logic primary_oscillator_in = 1'b0, secondary_oscillator_in = 1'b0;
	logic low_freq_internal_osc_in = 1'b0, fast_internal_rc_in = 1'b0;
	logic peripheral_clock_source = 1'b0;
	logic [2:0] sys_clk_select;
	logic osc_startup_timer_clear, pll_stop, sleep_active, idle_active;
	logic ref_clock_out_pin_a, ref_clock_out_pin_a_oe;
	logic ref_clock_out_pin_b, ref_clock_out_pin_b_oe;
	logic [31:0] seed = 32'h000176dd;
	int n_fail = 0, total_checks = 0, n_clr = 0, cnt = 0, per[2], rise[2];
	wire [1:0] oe = {ref_clock_out_pin_b_oe, ref_clock_out_pin_a_oe};
	wire [1:0] pin = {ref_clock_out_pin_b, ref_clock_out_pin_a};

	cso_top #(.OST_CYCLES(4)) u_dut (.*);
	cso_ref_sink u_sink_a (.aclk(aclk), .pin(ref_clock_out_pin_a),
		.oe(ref_clock_out_pin_a_oe), .period(per[0]), .rises(rise[0]));
	cso_ref_sink u_sink_b (.aclk(aclk), .pin(ref_clock_out_pin_b),
		.oe(ref_clock_out_pin_b_oe), .period(per[1]), .rises(rise[1]));

	always #2 aclk = ~aclk;
	// free-running source levels, all slower than aclk/2
	always @(posedge aclk) begin
		cnt <= cnt + 1;
		primary_oscillator_in <= (cnt % 6) < 3;
		secondary_oscillator_in <= (cnt % 10) < 5;
		low_freq_internal_osc_in <= (cnt % 14) < 7;
		fast_internal_rc_in <= (cnt % 8) < 4;
		peripheral_clock_source <= (cnt % 12) < 6;
		if (osc_startup_timer_clear)
			n_clr <= n_clr + 1;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// source periods in aclk cycles, indexed by source code
	function automatic int exp_per(input logic [3:0] s, input int n);
		int p[6] = '{2, 12, 6, 10, 14, 8};
		return (n == 0) ? p[s] : p[s] * 2 * n;
	endfunction : exp_per

	task automatic stop_test();
		if (n_fail == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wt(input int w, input int i, input int t);
		logic h;
		for (int k = 0; k < 3000; k++) begin
			@(posedge aclk);
			case (w)
				0: h = s_axi_awready;
				1: h = s_axi_bvalid;
				2: h = s_axi_arready;
				3: h = s_axi_rvalid;
				4: h = (sys_clk_select === OSC_PRI);
				5: h = (rise[i] >= t);
				default: h = !oe[i];
			endcase
			if (h === 1'b1)
				return;
		end
		n_fail++;
		$display("mismatch at %0t: wait %h timed out at %h", $time, w, t);
		stop_test();
	endtask : wt
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		wt(0, 0, 0);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		@(posedge aclk);
		s_axi_bready <= 1'b1;
		wt(1, 0, 0);
		chk({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		wt(2, 0, 0);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		wt(3, 0, 0);
		rdv = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rdv, e);
		chk({30'h0, rsp}, {30'h0, RESP_OKAY});
	endtask : rdc
	// 0 sleep, 1 idle, 2 wake; returns once the power state has landed
	task automatic pulse(input int w);
		sleep_req <= (w == 0);
		idle_req <= (w == 1);
		wake_req <= (w == 2);
		@(posedge aclk);
		sleep_req <= 1'b0;
		idle_req <= 1'b0;
		wake_req <= 1'b0;
		@(posedge aclk);
	endtask : pulse
	task automatic ref_set(input int i, input logic [3:0] s,
		input logic [14:0] n, input logic [7:0] con);
		logic [7:0] b;
		b = 8'h10 + 8'(i * 16);
		wr(b + 8'h04, {28'h0, s});
		wr(b + 8'h08, {17'h0, n});
		wr(b, {24'h0, con});
		wt(5, i, rise[i] + 2);
	endtask : ref_set
	task automatic ref_off(input int i);
		wr(8'h10 + 8'(i * 16), 32'h0);
		wt(6, i, 0);
		@(posedge aclk);
		chk({31'h0, pin[i]}, 32'h0);
	endtask : ref_off
	task automatic ref_run(input int i, input logic [3:0] s,
		input logic [14:0] n);
		ref_set(i, s, n, 8'h80);
		wt(5, i, rise[i] + 2);
		chk(per[i], exp_per(s, n));
		chk({31'h0, oe[1 - i]}, 32'h0);
		ref_off(i);
	endtask : ref_run

	initial begin
		logic [3:0] s;
		logic [14:0] n;
		int r;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdc(OFF_CFG, 32'h82);
		rdc(OFF_OSC, 32'h102);
		chk({29'h0, sys_clk_select}, 32'h0);
		osc_stable_in <= 4'b1001;
		wt(4, 0, 0);
		rdc(OFF_OSC, 32'h22);
		rdc(OFF_STAT, 32'h24);
		rd(8'hfc);
		chk(rdv, 32'h0);
		chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
		wr(OFF_OSC, 32'h4);
		rdc(OFF_OSC, 32'h124);
		wr(OFF_OSC, 32'h2);
		repeat (3) @(posedge aclk);
		chk(n_clr, 32'h1);
		osc_stable_in <= 4'b1000;
		wr(OFF_OSC, 32'h5);
		pulse(0);
		chk({31'h0, sleep_active}, 32'h1);
		rdc(OFF_OSC, 32'h22);
		chk(n_clr, 32'h2);
		pulse(2);
		rdc(OFF_OSC, 32'h102);
		chk({29'h0, sys_clk_select}, 32'h0);
		wr(OFF_OSC, 32'h0);
		rdc(OFF_OSC, 32'h0);
		pulse(0);
		pulse(2);
		rdc(OFF_OSC, 32'h102);
		osc_stable_in <= 4'b1001;
		wt(4, 0, 0);
		pulse(1);
		chk({31'h0, idle_active}, 32'h1);
		pulse(2);
		rdc(OFF_OSC, 32'h22);
		wr(OFF_CFG, 32'h2);
		pulse(0);
		pulse(2);
		rdc(OFF_OSC, 32'h22);
		wr(OFF_CFG, 32'h82);
		for (int j = 0; j < 6; j++) begin
			s = 4'(j);
			n = 15'(rnd() % 3);
			if (j == 0 && n == 15'h0)
				n = 15'h1;
			ref_run(int'(rnd() & 32'h1), s, n);
		end
		ref_run(1, REF_PRI, 15'h0);
		wr(8'h18, 32'h7fff);
		rdc(8'h18, 32'h7fff);
		wr(OFF_PMD, 32'h1);
		wr(8'h10, 32'h80);
		repeat (40) @(posedge aclk);
		chk({31'h0, ref_clock_out_pin_a_oe}, 32'h0);
		wr(8'h14, 32'h6);
		wr(OFF_PMD, 32'h0);
		repeat (40) @(posedge aclk);
		chk({31'h0, ref_clock_out_pin_a_oe}, 32'h0);
		ref_off(0);
		ref_set(0, REF_PRI, 15'h1, 8'h88);
		pulse(0);
		@(posedge aclk);
		chk({30'h0, osc_keep_req}, 32'h1);
		wt(5, 0, rise[0] + 3);
		pulse(2);
		ref_off(0);
		ref_set(0, REF_PERIPH, 15'h1, 8'h88);
		pulse(0);
		repeat (30) @(posedge aclk);
		chk({30'h0, osc_keep_req}, 32'h0);
		r = rise[0];
		repeat (60) @(posedge aclk);
		chk(rise[0], r);
		pulse(2);
		ref_off(0);
		stop_test();
	end
endmodule : tb
